// ===== design/wdr_top.sv
`timescale 1ns/1ps
module wdr_top
	import wdr_pkg::*;
#(
	parameter int BASE_TICKS_P = WDR_BASE_TICKS,
	parameter int DIV_P = WDR_DIV
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [WDR_AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [WDR_AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic always_on_fuse_i,
	input wire logic ext_rst_i,
	input wire logic bod_rst_i,
	input wire logic irq_ack_i,
	output logic wdog_irq_o,
	output logic sys_rst_o,
	output logic [15:0] vec_addr_o
);
	typedef struct packed {
		logic irqf;
		logic ie;
		logic wdog_reset_enable;
		logic [3:0] tsel;
		logic [3:0] cause;
		logic [WDR_CNT_W-1:0] cnt;
		logic [2:0] key_left;
		logic [3:0] rst_cnt;
		logic rst;
		logic irq;
		logic [15:0] vec;
	} wdr_core_t;

	wdr_core_t s_r, s_nxt;
	wdr_reg_req_t req;
	logic [7:0] rdata;
	logic [7:0] ctrl_rd;
	logic tick;
	logic fuse_prog;
	logic wde_eff;
	logic combined;
	logic run;
	logic [3:0] tsel_eff;
	logic [WDR_CNT_W:0] limit;
	logic timeout;
	logic wd_reset;
	logic flag_set;
	logic sys_evt;
	logic armed;
	logic ctrl_wr;
	logic flag_wr;
	logic key_wr;
	logic kick_wr;

	wdr_axi u_axi (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.awaddr_i(s_axi_awaddr_i),
		.awvalid_i(s_axi_awvalid_i),
		.awready_o(s_axi_awready_o),
		.wdata_i(s_axi_wdata_i),
		.wstrb_i(s_axi_wstrb_i),
		.wvalid_i(s_axi_wvalid_i),
		.wready_o(s_axi_wready_o),
		.bresp_o(s_axi_bresp_o),
		.bvalid_o(s_axi_bvalid_o),
		.bready_i(s_axi_bready_i),
		.araddr_i(s_axi_araddr_i),
		.arvalid_i(s_axi_arvalid_i),
		.arready_o(s_axi_arready_o),
		.rdata_o(s_axi_rdata_o),
		.rresp_o(s_axi_rresp_o),
		.rvalid_o(s_axi_rvalid_o),
		.rready_i(s_axi_rready_i),
		.req_o(req),
		.rdata_i(rdata)
	);

	// Slow oscillator modelled as an enable so the block keeps one clock domain
	wdr_tick #(
		.DIV_P(DIV_P)
	) u_tick (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.tick_o(tick)
	);

	assign ctrl_wr = req.wr && (req.widx == WDR_IDX_CTRL);
	assign flag_wr = req.wr && (req.widx == WDR_IDX_FLAGS);
	assign key_wr = req.wr && (req.widx == WDR_IDX_KEY);
	assign kick_wr = req.wr && (req.widx == WDR_IDX_KICK);
	assign armed = (s_r.key_left != 3'h0);

	assign fuse_prog = !always_on_fuse_i;
	assign wde_eff = s_r.wdog_reset_enable || fuse_prog || s_r.cause[WDR_FB_WDOG];
	assign combined = !fuse_prog && wde_eff && s_r.ie;
	assign run = wde_eff || s_r.ie;

	// Reserved select codes behave as the longest period
	assign tsel_eff = (s_r.tsel > WDR_TSEL_MAX) ? WDR_TSEL_MAX : s_r.tsel;
	assign limit = (WDR_CNT_W + 1)'(BASE_TICKS_P) << tsel_eff;
	assign timeout = run && tick && !s_r.rst && (s_r.cnt == WDR_CNT_W'(limit - 1'b1));
	assign wd_reset = timeout && wde_eff && (!s_r.ie || fuse_prog || s_r.irqf);
	assign flag_set = timeout && s_r.ie && !wd_reset;
	assign sys_evt = wd_reset || ext_rst_i || bod_rst_i;

	always_comb begin
		ctrl_rd = 8'h00;
		ctrl_rd[WDR_CB_IRQF] = s_r.irqf;
		ctrl_rd[WDR_CB_IE] = s_r.ie;
		ctrl_rd[WDR_CB_TS3] = s_r.tsel[3];
		ctrl_rd[WDR_CB_WDE] = wde_eff;
		ctrl_rd[WDR_CB_TS_HI:0] = s_r.tsel[2:0];
		case (req.ridx)
			WDR_IDX_CTRL: rdata = ctrl_rd;
			WDR_IDX_FLAGS: rdata = {WDR_RSVD_HI, s_r.cause};
			default: rdata = 8'h00;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		if (s_r.rst_cnt != 4'h0) begin
			s_nxt.rst_cnt = s_r.rst_cnt - 4'h1;
		end
		if (key_wr && (req.wdata == WDR_KEY)) begin
			s_nxt.key_left = WDR_KEY_WRITES;
		end else if (req.wr && armed) begin
			s_nxt.key_left = s_r.key_left - 3'h1;
		end
		if (ctrl_wr) begin
			if (req.wdata[WDR_CB_IRQF]) begin
				s_nxt.irqf = 1'b0;
			end
			s_nxt.ie = req.wdata[WDR_CB_IE];
			// With the fuse programmed only a keyed write may shorten or stretch the period
			if (!fuse_prog || armed) begin
				s_nxt.tsel = {req.wdata[WDR_CB_TS3], req.wdata[WDR_CB_TS_HI:0]};
			end
			if (req.wdata[WDR_CB_WDE] || !s_r.wdog_reset_enable || armed) begin
				s_nxt.wdog_reset_enable = req.wdata[WDR_CB_WDE];
			end
		end
		if (irq_ack_i && s_r.irqf) begin
			s_nxt.irqf = 1'b0;
			if (combined) begin
				s_nxt.ie = 1'b0;
			end
		end
		// A time-out in the cycle of a clear keeps the flag
		if (flag_set) begin
			s_nxt.irqf = 1'b1;
		end
		if (flag_wr) begin
			s_nxt.cause = s_r.cause & req.wdata[3:0];
		end
		if (kick_wr || !run || timeout || s_r.rst) begin
			s_nxt.cnt = '0;
		end else if (tick) begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end
		if (sys_evt) begin
			s_nxt.irqf = 1'b0;
			s_nxt.ie = 1'b0;
			s_nxt.wdog_reset_enable = 1'b0;
			s_nxt.tsel = 4'h0;
			s_nxt.cnt = '0;
			s_nxt.key_left = 3'h0;
			// A new source during a pulse is recorded but does not stretch it
			if (!s_r.rst) begin
				s_nxt.rst_cnt = WDR_RST_CYCLES;
			end
		end
		if (wd_reset) begin
			s_nxt.cause[WDR_FB_WDOG] = 1'b1;
		end
		if (bod_rst_i) begin
			s_nxt.cause[WDR_FB_BOD] = 1'b1;
		end
		if (ext_rst_i) begin
			s_nxt.cause[WDR_FB_PIN] = 1'b1;
		end
		s_nxt.wdog_reset_enable = s_nxt.wdog_reset_enable || s_nxt.cause[WDR_FB_WDOG];
		s_nxt.rst = (s_nxt.rst_cnt != 4'h0);
		s_nxt.irq = s_nxt.irqf && s_nxt.ie;
		s_nxt.vec = s_nxt.rst ? WDR_VEC_RESET : WDR_VEC_WDOG;
	end

	// Async reset stands for power-on: only the power-on cause survives it
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= '0;
			s_r.cause <= WDR_CAUSE_POR_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wdog_irq_o = s_r.irq;
	assign sys_rst_o = s_r.rst;
	assign vec_addr_o = s_r.vec;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	property p_irq_mode;
		timeout && !fuse_prog && !wde_eff && s_r.ie && !sys_evt |=> wdog_irq_o && !sys_rst_o;
	endproperty
	a_irq_mode: assert property (p_irq_mode) else $error("interrupt mode time-out lost");

	property p_combined_first;
		timeout && combined && !s_r.irqf && !ext_rst_i && !bod_rst_i |=> s_r.irqf && !sys_rst_o;
	endproperty
	a_combined_first: assert property (p_combined_first) else $error("combined first time-out wrong");

	property p_ack_clears;
		irq_ack_i && s_r.irqf && combined && !timeout && !ctrl_wr && !sys_evt |=> !s_r.ie && !s_r.irqf;
	endproperty
	a_ack_clears: assert property (p_ack_clears) else $error("vector did not clear enable and flag");

	property p_combined_second;
		timeout && combined && s_r.irqf && !s_r.rst |=> sys_rst_o && s_r.cause[WDR_FB_WDOG];
	endproperty
	a_combined_second: assert property (p_combined_second) else $error("no reset on second time-out");

	property p_fuse_forces;
		fuse_prog |-> ctrl_rd[WDR_CB_WDE] && run;
	endproperty
	a_fuse_forces: assert property (p_fuse_forces) else $error("fuse did not force reset mode");

	property p_stopped;
		!fuse_prog && !wde_eff && !s_r.ie ##1 !fuse_prog && !wde_eff && !s_r.ie |-> s_r.cnt == '0;
	endproperty
	a_stopped: assert property (p_stopped) else $error("stopped watchdog counting");

	// The whole high nibble is reserved in the cause register; control keeps bit 4 reserved and uses bits 7 to 5 for live fields
	property p_reserved_zero;
		!ctrl_rd[4] && (req.ridx != WDR_IDX_FLAGS || rdata[7:4] == WDR_RSVD_HI);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit reads one");

	property p_cause_forces_wde;
		s_r.cause[WDR_FB_WDOG] |-> s_r.wdog_reset_enable && ctrl_rd[WDR_CB_WDE];
	endproperty
	a_cause_forces_wde: assert property (p_cause_forces_wde) else $error("reset enable clear with cause flag");

	property p_period;
		timeout |-> 32'(s_r.cnt) + 32'h1 == 32'(BASE_TICKS_P) << tsel_eff;
	endproperty
	a_period: assert property (p_period) else $error("time-out at wrong count");

	property p_por_only_sw;
		$fell(s_r.cause[WDR_FB_POR]) |-> $past(flag_wr) && !$past(req.wdata[WDR_FB_POR]);
	endproperty
	a_por_only_sw: assert property (p_por_only_sw) else $error("power-on flag cleared by hardware");

	property p_kick;
		kick_wr |=> s_r.cnt == '0;
	endproperty
	a_kick: assert property (p_kick) else $error("restart did not clear counter");

	property p_pulse;
		$rose(sys_rst_o) |-> sys_rst_o[*8] ##1 !sys_rst_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse length wrong");

	property p_vec;
		sys_rst_o |-> vec_addr_o == WDR_VEC_RESET;
	endproperty
	a_vec: assert property (p_vec) else $error("reset vector wrong");

	property p_unkeyed_disable;
		ctrl_wr && !armed && s_r.wdog_reset_enable && !req.wdata[WDR_CB_WDE] && !sys_evt |=> s_r.wdog_reset_enable;
	endproperty
	a_unkeyed_disable: assert property (p_unkeyed_disable) else $error("reset enable cleared without key");

	property p_flag_w1c;
		ctrl_wr && req.wdata[WDR_CB_IRQF] && !flag_set |=> !s_r.irqf;
	endproperty
	a_flag_w1c: assert property (p_flag_w1c) else $error("interrupt flag kept after write of one");

	property p_tsel_field;
		ctrl_wr && !fuse_prog && !sys_evt |=>
			s_r.tsel == {$past(req.wdata[WDR_CB_TS3]), $past(req.wdata[WDR_CB_TS_HI:0])};
	endproperty
	a_tsel_field: assert property (p_tsel_field) else $error("time-out select field misplaced");

	property p_pin_cause;
		ext_rst_i |=> s_r.cause[WDR_FB_PIN];
	endproperty
	a_pin_cause: assert property (p_pin_cause) else $error("pin reset not recorded");

	property p_bod_cause;
		bod_rst_i |=> s_r.cause[WDR_FB_BOD];
	endproperty
	a_bod_cause: assert property (p_bod_cause) else $error("brown-out reset not recorded");

	property p_wdog_cause;
		wd_reset |=> s_r.cause[WDR_FB_WDOG] && sys_rst_o;
	endproperty
	a_wdog_cause: assert property (p_wdog_cause) else $error("watchdog reset not recorded");

	c_combined_irq: cover property (timeout && combined && !s_r.irqf);
	c_wdog_reset: cover property (wd_reset ##1 sys_rst_o);
	c_keyed_write: cover property (armed && ctrl_wr);
	c_ack_combined: cover property (irq_ack_i && s_r.irqf && combined);
	c_fuse_reset: cover property (fuse_prog && wd_reset);
endmodule : wdr_top

// ===== shared/wdr_pkg.sv
package wdr_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0] WDR_IDX_KICK = 6'h30;
	localparam logic [5:0] WDR_IDX_CTRL = 6'h31;
	localparam logic [5:0] WDR_IDX_KEY = 6'h32;
	localparam logic [5:0] WDR_IDX_FLAGS = 6'h3B;
	localparam int WDR_AW = 8;
	localparam int WDR_IDX_LSB = 2;
	// Control and status fields
	localparam int WDR_CB_IRQF = 7;
	localparam int WDR_CB_IE = 6;
	localparam int WDR_CB_TS3 = 5;
	localparam int WDR_CB_WDE = 3;
	localparam int WDR_CB_TS_HI = 2;
	// Reset-cause fields
	localparam int WDR_FB_WDOG = 3;
	localparam int WDR_FB_BOD = 2;
	localparam int WDR_FB_PIN = 1;
	localparam int WDR_FB_POR = 0;
	localparam logic [3:0] WDR_CAUSE_POR_RST = 4'h1;
	localparam logic [3:0] WDR_RSVD_HI = 4'h0;
	// Timing
	localparam int WDR_CLK_MHZ = 125;
	localparam int WDR_OSC_KHZ = 128;
	localparam int WDR_DIV = WDR_CLK_MHZ * 1000 / WDR_OSC_KHZ;
	localparam int WDR_BASE_TICKS = 2048;
	localparam int WDR_CNT_W = 20;
	localparam logic [3:0] WDR_TSEL_MAX = 4'h9;
	localparam int WDR_RST_NS = 64;
	localparam logic [3:0] WDR_RST_CYCLES = 4'(WDR_RST_NS * WDR_CLK_MHZ / 1000);
	// Protected change
	localparam logic [7:0] WDR_KEY = 8'hD8;
	localparam logic [2:0] WDR_KEY_WRITES = 3'h4;
	// Program addresses
	localparam logic [15:0] WDR_VEC_RESET = 16'h0000;
	localparam logic [15:0] WDR_VEC_WDOG = 16'h0005;
	// Bus answers
	localparam logic [1:0] WDR_RESP_OKAY = 2'h0;
	localparam logic [1:0] WDR_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic wr;
		logic [5:0] widx;
		logic [7:0] wdata;
		logic [5:0] ridx;
	} wdr_reg_req_t;

	function automatic logic wdr_hit(input logic [5:0] idx);
		return (idx == WDR_IDX_KICK) || (idx == WDR_IDX_CTRL) || (idx == WDR_IDX_KEY) || (idx == WDR_IDX_FLAGS);
	endfunction : wdr_hit
endpackage : wdr_pkg

// ===== design/wdr_tick.sv
`timescale 1ns/1ps
module wdr_tick
	import wdr_pkg::*;
#(
	parameter int DIV_P = WDR_DIV
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	output logic tick_o
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} wdr_tick_t;
	wdr_tick_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = (s_r.cnt == 16'(DIV_P - 1));
		s_nxt.cnt = s_nxt.tick ? 16'h0000 : s_r.cnt + 16'h0001;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick_o = s_r.tick;
endmodule : wdr_tick

// ===== design/wdr_axi.sv
`timescale 1ns/1ps
module wdr_axi
	import wdr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [WDR_AW-1:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [WDR_AW-1:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	output wdr_reg_req_t req_o,
	input wire logic [7:0] rdata_i
);
	typedef struct packed {
		logic awrdy;
		logic wrdy;
		logic arrdy;
		logic aw_ok;
		logic w_ok;
		logic [5:0] widx;
		logic [7:0] wdat;
		logic wen;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} wdr_axi_t;
	wdr_axi_t s_r, s_nxt;
	logic [5:0] ridx;

	assign ridx = araddr_i[WDR_AW-1:WDR_IDX_LSB];

	always_comb begin
		s_nxt = s_r;
		if (awvalid_i && s_r.awrdy) begin
			s_nxt.aw_ok = 1'b1;
			s_nxt.widx = awaddr_i[WDR_AW-1:WDR_IDX_LSB];
		end
		if (wvalid_i && s_r.wrdy) begin
			s_nxt.w_ok = 1'b1;
			s_nxt.wdat = wdata_i[7:0];
			s_nxt.wen = wstrb_i[0];
		end
		if (s_r.bvalid && bready_i) begin
			s_nxt.bvalid = 1'b0;
		end
		// Address and data may arrive in either order; answer once both are held
		if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid) begin
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = wdr_hit(s_r.widx) ? WDR_RESP_OKAY : WDR_RESP_SLVERR;
			s_nxt.aw_ok = 1'b0;
			s_nxt.w_ok = 1'b0;
		end
		if (s_r.rvalid && rready_i) begin
			s_nxt.rvalid = 1'b0;
		end
		if (arvalid_i && s_r.arrdy) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = {24'h000000, rdata_i};
			s_nxt.rresp = wdr_hit(ridx) ? WDR_RESP_OKAY : WDR_RESP_SLVERR;
		end
		s_nxt.awrdy = !s_nxt.aw_ok && !s_nxt.bvalid;
		s_nxt.wrdy = !s_nxt.w_ok && !s_nxt.bvalid;
		s_nxt.arrdy = !s_nxt.rvalid;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign req_o.wr = s_r.aw_ok && s_r.w_ok && !s_r.bvalid && s_r.wen && wdr_hit(s_r.widx);
	assign req_o.widx = s_r.widx;
	assign req_o.wdata = s_r.wdat;
	assign req_o.ridx = ridx;
	assign awready_o = s_r.awrdy;
	assign wready_o = s_r.wrdy;
	assign arready_o = s_r.arrdy;
	assign bvalid_o = s_r.bvalid;
	assign bresp_o = s_r.bresp;
	assign rvalid_o = s_r.rvalid;
	assign rdata_o = s_r.rdata;
	assign rresp_o = s_r.rresp;
endmodule : wdr_axi

// ===== test/tb_wdr_top.sv
`timescale 1ns/1ps
module tb_wdr_top;
	import wdr_pkg::*;
	// Short tick and base count keep every time-out code inside the run
	localparam int BT = 4;
	localparam int DV = 4;
	localparam logic [1:0] OK = WDR_RESP_OKAY;
	localparam logic [1:0] ER = WDR_RESP_SLVERR;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, v;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, sys_rst;
	logic [1:0] bresp, rresp;
	logic [15:0] vec;
	logic fuse = 1'b1, ext_rst = 1'b0, bod_rst = 1'b0, irq_ack = 1'b0;
	logic [31:0] seed = 32'hC36A;
	int fails = 0, n_checks = 0, cyc;

	always #4 clk_i = ~clk_i;

	wdr_top #(.BASE_TICKS_P(BT), .DIV_P(DV)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.always_on_fuse_i(fuse), .ext_rst_i(ext_rst), .bod_rst_i(bod_rst), .irq_ack_i(irq_ack),
		.wdog_irq_o(irq), .sys_rst_o(sys_rst), .vec_addr_o(vec));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic int tmo(input int t);
		return (BT << t) * DV;
	endfunction : tmo

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t ns: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : chk_val

	task automatic chk_flag(input logic got, input logic exp, input string what);
		chk_val({31'h0, got}, {31'h0, exp}, what);
	endtask : chk_flag

	task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
		int n;
		bit b;
		n = 0;
		b = 0;
		@(posedge clk_i);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b && n < 100) begin
			@(posedge clk_i);
			n++;
			if (awvalid && awready === 1'b1) begin
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				wvalid <= 1'b0;
			end
			if (bvalid === 1'b1) begin
				b = 1;
				bready <= 1'b0;
				chk_val({30'h0, bresp}, {30'h0, er}, "write response");
			end
		end
		chk_flag(b, 1'b1, "write never answered");
	endtask : wr

	task automatic rd(input logic [5:0] idx, input logic [7:0] ed, input logic [1:0] er);
		int n;
		bit d;
		n = 0;
		d = 0;
		@(posedge clk_i);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!d && n < 100) begin
			@(posedge clk_i);
			n++;
			if (arvalid && arready === 1'b1) begin
				arvalid <= 1'b0;
			end
			if (rvalid === 1'b1) begin
				d = 1;
				rready <= 1'b0;
				chk_val(rdata, {24'h0, ed}, "read data");
				chk_val({30'h0, rresp}, {30'h0, er}, "read response");
			end
		end
		chk_flag(d, 1'b1, "read never answered");
	endtask : rd

	task automatic wait_for(input bit on_rst, input int lim);
		cyc = 0;
		while (((on_rst ? sys_rst : irq) !== 1'b1) && cyc < lim) begin
			@(negedge clk_i);
			cyc++;
		end
		chk_flag(cyc < lim, 1'b1, "event never came");
	endtask : wait_for

	task automatic rst_pulse(input int lim);
		int len;
		wait_for(1, lim);
		chk_val({16'h0, vec}, {16'h0, WDR_VEC_RESET}, "vector during reset");
		len = 0;
		while (sys_rst === 1'b1 && len < 50) begin
			@(negedge clk_i);
			len++;
		end
		chk_val(32'(len), {28'h0, WDR_RST_CYCLES}, "reset pulse length");
	endtask : rst_pulse

	// Forced reset mode restarts at the shortest code, so the long code goes in first
	task automatic recover;
		wr(WDR_IDX_CTRL, 8'h29, OK);
		wr(WDR_IDX_FLAGS, 8'h01, OK);
		wr(WDR_IDX_KEY, WDR_KEY, OK);
		wr(WDR_IDX_CTRL, 8'h00, OK);
		rd(WDR_IDX_CTRL, 8'h00, OK);
		rd(WDR_IDX_FLAGS, 8'h01, OK);
	endtask : recover

	task automatic por;
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask : por

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (60000) @(posedge clk_i);
		fails++;
		end_of_test();
	end

	initial begin
		por();
		rd(WDR_IDX_FLAGS, 8'h01, OK);
		rd(WDR_IDX_CTRL, 8'h00, OK);
		chk_val({16'h0, vec}, {16'h0, WDR_VEC_WDOG}, "idle vector");
		wr(WDR_IDX_FLAGS, 8'h00, OK);
		wr(WDR_IDX_FLAGS, 8'hF0, OK);
		rd(WDR_IDX_FLAGS, 8'h00, OK);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr({2'b00, seed[3:0]}, seed[11:4], ER);
			rd({2'b00, seed[3:0]}, 8'h00, ER);
		end
		rd(WDR_IDX_FLAGS, 8'h00, OK);
		// Later expectations count on the power-on cause being set again
		por();
		rd(WDR_IDX_FLAGS, 8'h01, OK);
		$display("test reset values and map finished");
		wr(WDR_IDX_CTRL, 8'h17, OK);
		rd(WDR_IDX_CTRL, 8'h07, OK);
		wr(WDR_IDX_CTRL, 8'h20, OK);
		rd(WDR_IDX_CTRL, 8'h20, OK);
		wr(WDR_IDX_CTRL, 8'h10, OK);
		repeat (100) @(negedge clk_i);
		chk_flag(irq | sys_rst, 1'b0, "stopped watchdog acted");
		$display("test stopped mode finished");
		for (int t = 0; t < 10; t++) begin
			v = 8'h40 | {2'b00, t[3], 2'b00, t[2:0]};
			wr(WDR_IDX_CTRL, v, OK);
			wait_for(0, tmo(t) + 20);
			chk_flag(cyc >= tmo(t) - DV - 3 && cyc <= tmo(t) + 6, 1'b1, "time-out period");
			chk_flag(sys_rst, 1'b0, "reset in interrupt mode");
			rd(WDR_IDX_CTRL, v | 8'h80, OK);
			wr(WDR_IDX_CTRL, 8'h80, OK);
			rd(WDR_IDX_CTRL, 8'h00, OK);
			chk_flag(irq, 1'b0, "interrupt after clear");
		end
		$display("test interrupt periods finished");
		wr(WDR_IDX_CTRL, 8'h41, OK);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			repeat (seed[2:0]) @(posedge clk_i);
			wr(WDR_IDX_KICK, seed[15:8], OK);
		end
		chk_flag(irq, 1'b0, "interrupt despite restart");
		wr(WDR_IDX_CTRL, 8'h00, OK);
		$display("test restart finished");
		wr(WDR_IDX_CTRL, 8'h49, OK);
		wait_for(0, tmo(1) + 20);
		chk_flag(sys_rst, 1'b0, "reset on first combined time-out");
		rd(WDR_IDX_CTRL, 8'hC9, OK);
		@(posedge clk_i);
		irq_ack <= 1'b1;
		@(posedge clk_i);
		irq_ack <= 1'b0;
		rd(WDR_IDX_CTRL, 8'h09, OK);
		wr(WDR_IDX_CTRL, 8'h49, OK);
		wait_for(0, tmo(1) + 20);
		chk_flag(sys_rst, 1'b0, "reset after re-arm");
		@(posedge clk_i);
		irq_ack <= 1'b1;
		@(posedge clk_i);
		irq_ack <= 1'b0;
		rst_pulse(tmo(1) + 20);
		rd(WDR_IDX_CTRL, 8'h08, OK);
		wr(WDR_IDX_CTRL, 8'h29, OK);
		rd(WDR_IDX_FLAGS, 8'h09, OK);
		wr(WDR_IDX_KEY, WDR_KEY, OK);
		wr(WDR_IDX_CTRL, 8'h21, OK);
		rd(WDR_IDX_CTRL, 8'h29, OK);
		recover();
		wr(WDR_IDX_CTRL, 8'h49, OK);
		wait_for(0, tmo(1) + 20);
		rst_pulse(tmo(1) + 20);
		recover();
		$display("test combined mode finished");
		@(posedge clk_i);
		ext_rst <= 1'b1;
		@(posedge clk_i);
		ext_rst <= 1'b0;
		rst_pulse(20);
		rd(WDR_IDX_FLAGS, 8'h03, OK);
		@(posedge clk_i);
		bod_rst <= 1'b1;
		@(posedge clk_i);
		bod_rst <= 1'b0;
		rst_pulse(20);
		rd(WDR_IDX_FLAGS, 8'h07, OK);
		wr(WDR_IDX_FLAGS, 8'h05, OK);
		rd(WDR_IDX_FLAGS, 8'h05, OK);
		wr(WDR_IDX_CTRL, 8'h29, OK);
		wr(WDR_IDX_CTRL, 8'h21, OK);
		rd(WDR_IDX_CTRL, 8'h29, OK);
		wr(WDR_IDX_KEY, WDR_KEY, OK);
		wr(WDR_IDX_CTRL, 8'h00, OK);
		$display("test pin and brown-out finished");
		fuse <= 1'b0;
		rd(WDR_IDX_CTRL, 8'h08, OK);
		rst_pulse(tmo(0) + 20);
		rd(WDR_IDX_FLAGS, 8'h0D, OK);
		fuse <= 1'b1;
		por();
		rd(WDR_IDX_FLAGS, 8'h01, OK);
		rd(WDR_IDX_CTRL, 8'h00, OK);
		$display("test fuse and power-on finished");
		end_of_test();
	end
endmodule : tb_wdr_top
